// [core/ovg_guard.sv]
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
// Behaviour
// - warning output high when any phase exceeds warn level, warning enabled.
// - fault output after phase above trip level for full fault delay.
// - warn and trip levels are percent of nominal, 1 % steps, default 110.
// - fault delay in 0.1 s steps, default 3 s.
// - overvoltage supervision only in ready/run with expansion module attached.
// - separate warning and fault enables, both off after reset.
// - overvoltage conditions clear only 5 % of threshold below threshold.
// - dip mode 0 none, 1 load shedding, 2 auto restart; default 0. Mode 2 does nothing here, same as mode 0.
// - load shedding evaluated only in mode 1, on average phase voltage.
// - shed status set, motor stopped, after average below dip level for delay.
// - shed status clears after average above restart level for restart delay.
// - on clear, 2-wire issues run command; 3-wire stays stopped.
// - overload mode leaves both logic outputs untouched by shedding.
// - independent mode leaves second logic output untouched by shedding.
// - changed shed or restart delay applies only from the next timer start; fault delay applies at once.
// - shedding disables both logic outputs, except per operating mode.
// - alarm indicator blinks five times per second while shedding.
// - shed and restart delays in whole seconds, defaults 10 s and 2 s.
// - dip and restart levels percent of nominal, defaults 70 and 90.
module ovg_guard (
    input  wire logic        sys_clk,     // 100 MHz clock
    input  wire logic        reset,       // synchronous, active high
    input  wire logic [15:0] phase_v1,    // L1-L2 voltage
    input  wire logic [15:0] phase_v2,    // L2-L3 voltage
    input  wire logic [15:0] phase_v3,    // L3-L1 voltage
    input  wire logic        module_ok,   // expansion module attached
    input  wire logic        motor_ready, // motor in ready state
    input  wire logic        motor_run,   // motor in run state
    input  wire logic        out1_req,    // logic output 1 request
    input  wire logic        out2_req,    // logic output 2 request
    input  wire logic [3:0]  reg_addr,    // register index
    input  wire logic [31:0] reg_wdata,   // write data
    input  wire logic        reg_wr,      // write strobe
    input  wire logic        reg_rd,      // read strobe
    output logic      [31:0] reg_rdata,   // read data, cycle after strobe
    output logic             ov_warn,     // overvoltage warning
    output logic             ov_fault,    // overvoltage fault
    output logic             shed_active, // load-shedding status
    output logic             motor_stop,  // stop command while shed
    output logic             run_cmd,     // one-cycle restart pulse
    output logic             logic_out1,  // gated logic output 1
    output logic             logic_out2,  // gated logic output 2
    output logic             alarm_led    // alarm indicator
);
    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0]  ctrl_q;
    logic [15:0] vnom_q;
    logic [7:0]  warn_level_q;
    logic [7:0]  trip_level_q;
    logic [15:0] ov_dly_q;
    logic [7:0]  dip_pct_q;
    logic [7:0]  rst_pct_q;
    logic [15:0] shed_dly_q;
    logic [15:0] rstr_dly_q;
    logic [15:0] ov_cnt_q;
    logic [15:0] shed_cnt_q;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ctrl_q       <= 8'h00;
            vnom_q       <= ovg_pkg::VNOM_RST;
            warn_level_q <= ovg_pkg::WARN_PCT_RST;
            trip_level_q <= ovg_pkg::TRIP_PCT_RST;
            ov_dly_q     <= ovg_pkg::OV_DLY_RST;
            dip_pct_q    <= ovg_pkg::DIP_PCT_RST;
            rst_pct_q    <= ovg_pkg::RST_PCT_RST;
            shed_dly_q   <= ovg_pkg::SHED_DLY_RST;
            rstr_dly_q   <= ovg_pkg::RSTR_DLY_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                ovg_pkg::REG_CTRL:   ctrl_q <= reg_wdata[7:0];
                ovg_pkg::REG_VNOM:   vnom_q <= reg_wdata[15:0];
                ovg_pkg::REG_OV_LVL: begin
                    warn_level_q <= reg_wdata[7:0];
                    trip_level_q <= reg_wdata[15:8];
                end
                ovg_pkg::REG_OV_DLY: ov_dly_q <= reg_wdata[15:0];
                ovg_pkg::REG_DIP_LVL: begin
                    dip_pct_q <= reg_wdata[7:0];
                    rst_pct_q <= reg_wdata[15:8];
                end
                ovg_pkg::REG_DIP_DLY: begin
                    shed_dly_q <= reg_wdata[15:0];
                    rstr_dly_q <= reg_wdata[31:16];
                end
                default: ;
            endcase
        end
    end
    logic       warn_en;
    logic       trip_en;
    logic [1:0] dip_mode;
    logic       two_wire;
    logic [1:0] op_mode;
    assign warn_en  = ctrl_q[ovg_pkg::CTRL_WARN_EN];
    assign trip_en  = ctrl_q[ovg_pkg::CTRL_TRIP_EN];
    assign dip_mode = ctrl_q[ovg_pkg::CTRL_MODE_LO +: 2];
    assign two_wire = ctrl_q[ovg_pkg::CTRL_TWO_WIRE];
    assign op_mode  = ctrl_q[ovg_pkg::CTRL_OPMODE_LO +: 2];
    ////////////////////////////////////////////////////////////////////////
    // 100 ms timebase
    localparam int TB_W = $clog2(ovg_pkg::TICK_CYCLES);
    logic [TB_W-1:0] tb_cnt_q;
    logic            tick_q;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tb_cnt_q <= '0;
            tick_q   <= 1'b0;
        end else if (tb_cnt_q == TB_W'(ovg_pkg::TICK_CYCLES - 1)) begin
            tb_cnt_q <= '0;
            tick_q   <= 1'b1;
        end else begin
            tb_cnt_q <= tb_cnt_q + 1'b1;
            tick_q   <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // level arithmetic: volts = vnom * pct / 100, compared as v*100
    logic [23:0] warn_thr;
    logic [23:0] trip_thr;
    logic [23:0] warn_clr;
    logic [23:0] trip_clr;
    logic [25:0] dip_thr;
    logic [25:0] rst_thr;
    logic [17:0] v_sum;
    logic [25:0] v_avg3;  // 26 bits: 3 * full scale * 100 overflows 24
    logic        ov_window;
    assign warn_thr = vnom_q * warn_level_q;
    assign trip_thr = vnom_q * trip_level_q;
    // hysteresis: clear level = thr * 95 / 100
    assign warn_clr = warn_thr - 24'(warn_thr * ovg_pkg::HYST_PCT / 100);
    assign trip_clr = trip_thr - 24'(trip_thr * ovg_pkg::HYST_PCT / 100);
    assign v_sum    = {2'b00, phase_v1} + {2'b00, phase_v2} + {2'b00, phase_v3};
    assign v_avg3   = 26'(v_sum) * 26'd100;
    assign dip_thr  = 26'(vnom_q * dip_pct_q * 3);
    assign rst_thr  = 26'(vnom_q * rst_pct_q * 3);
    assign ov_window = module_ok && (motor_ready || motor_run);
    logic [2:0] above_warn;
    logic [2:0] above_wclr;
    logic [2:0] above_trip;
    logic [2:0] above_tclr;
    logic [15:0] phase [3];
    assign phase[0] = phase_v1;
    assign phase[1] = phase_v2;
    assign phase[2] = phase_v3;
    for (genvar gi = 0; gi < 3; gi++) begin : g_ph
        logic [23:0] v100;
        assign v100 = 24'(phase[gi]) * 24'd100;
        assign above_warn[gi] = v100 > warn_thr;
        assign above_wclr[gi] = v100 > warn_clr;
        assign above_trip[gi] = v100 > trip_thr;
        assign above_tclr[gi] = v100 > trip_clr;
    end
    ////////////////////////////////////////////////////////////////////////
    // overvoltage warning and fault
    logic        trip_cond_q;
    logic [15:0] ov_tmr_q;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ov_warn <= 1'b0;
        end else if (!ov_window || !warn_en) begin
            ov_warn <= 1'b0;
        end else if (|above_warn) begin
            ov_warn <= 1'b1;
        end else if (!(|above_wclr)) begin
            ov_warn <= 1'b0;
        end
    end
    // trip condition with hysteresis; timer restarts whenever it drops
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            trip_cond_q <= 1'b0;
        end else if (|above_trip) begin
            trip_cond_q <= 1'b1;
        end else if (!(|above_tclr)) begin
            trip_cond_q <= 1'b0;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ov_tmr_q <= '0;
            ov_fault <= 1'b0;
        end else if (!ov_window || !trip_en || !trip_cond_q) begin
            ov_tmr_q <= '0;
            ov_fault <= 1'b0;
        end else if (ov_tmr_q >= ov_dly_q) begin
            ov_fault <= 1'b1;
        end else if (tick_q) begin
            ov_tmr_q <= ov_tmr_q + 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // load shedding
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_DIP   = 2'b01,
        ST_SHED  = 2'b11,
        ST_RECOV = 2'b10
    } ovg_shed_type;
    ovg_shed_type shed_q;
    logic [15:0]  sec_tmr_q;   // whole seconds
    logic [3:0]   sub_q;       // ticks within a second
    logic [15:0]  dly_lat_q;   // duration latched at timer start
    logic         below_dip;
    logic         above_rst;
    logic         run_pend_q;  // restart owed; issued as the status falls
    assign below_dip = v_avg3 < dip_thr;
    assign above_rst = v_avg3 > rst_thr;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            shed_q     <= ST_IDLE;
            sec_tmr_q  <= '0;
            sub_q      <= '0;
            dly_lat_q  <= '0;
            run_pend_q <= 1'b0;
        end else begin
            run_pend_q <= 1'b0;
            case (shed_q)
                ST_IDLE: begin
                    if (dip_mode == ovg_pkg::MODE_SHED && below_dip) begin
                        shed_q    <= ST_DIP;
                        sec_tmr_q <= '0;
                        sub_q     <= '0;
                        dly_lat_q <= shed_dly_q;
                    end
                end
                ST_DIP: begin
                    if (dip_mode != ovg_pkg::MODE_SHED || !below_dip) begin
                        shed_q <= ST_IDLE;
                    end else if (sec_tmr_q >= dly_lat_q) begin
                        shed_q <= ST_SHED;
                    end else if (tick_q) begin
                        if (sub_q == ovg_pkg::TICKS_PER_S - 4'h1) begin
                            sub_q     <= '0;
                            sec_tmr_q <= sec_tmr_q + 1'b1;
                        end else begin
                            sub_q <= sub_q + 1'b1;
                        end
                    end
                end
                ST_SHED: begin
                    if (dip_mode != ovg_pkg::MODE_SHED) begin
                        shed_q <= ST_IDLE;
                    end else if (above_rst) begin
                        shed_q    <= ST_RECOV;
                        sec_tmr_q <= '0;
                        sub_q     <= '0;
                        dly_lat_q <= rstr_dly_q;
                    end
                end
                ST_RECOV: begin
                    if (dip_mode != ovg_pkg::MODE_SHED) begin
                        shed_q <= ST_IDLE;
                    end else if (!above_rst) begin
                        shed_q <= ST_SHED;
                    end else if (sec_tmr_q >= dly_lat_q) begin
                        shed_q     <= ST_IDLE;
                        run_pend_q <= two_wire;
                    end else if (tick_q) begin
                        if (sub_q == ovg_pkg::TICKS_PER_S - 4'h1) begin
                            sub_q     <= '0;
                            sec_tmr_q <= sec_tmr_q + 1'b1;
                        end else begin
                            sub_q <= sub_q + 1'b1;
                        end
                    end
                end
                default: shed_q <= ST_IDLE;
            endcase
        end
    end
    logic shed_now;
    assign shed_now = (shed_q == ST_SHED) || (shed_q == ST_RECOV);
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            shed_active <= 1'b0;
            motor_stop  <= 1'b0;
            run_cmd     <= 1'b0;
        end else begin
            shed_active <= shed_now;
            motor_stop  <= shed_now;
            run_cmd     <= run_pend_q;
        end
    end
    // logic output gating per operating mode
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            logic_out1 <= 1'b0;
            logic_out2 <= 1'b0;
        end else begin
            logic_out1 <= out1_req &&
                (!shed_now || op_mode == ovg_pkg::OPM_OVERLOAD);
            logic_out2 <= out2_req &&
                (!shed_now || op_mode == ovg_pkg::OPM_OVERLOAD ||
                 op_mode == ovg_pkg::OPM_INDEPENDENT);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // alarm blink: toggle every 100 ms gives 5 flashes per second
    logic [7:0] blink_q;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            blink_q   <= '0;
            alarm_led <= 1'b0;
        end else if (!shed_now) begin
            blink_q   <= '0;
            alarm_led <= 1'b0;
        end else if (tick_q) begin
            if (blink_q >= ovg_pkg::BLINK_TICKS - 8'h01) begin
                blink_q   <= '0;
                alarm_led <= ~alarm_led;
            end else begin
                blink_q <= blink_q + 1'b1;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // statistics, saturating
    logic ov_fault_prev_q;
    logic shed_prev_q;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ov_fault_prev_q <= 1'b0;
            shed_prev_q     <= 1'b0;
            ov_cnt_q        <= '0;
            shed_cnt_q      <= '0;
        end else begin
            ov_fault_prev_q <= ov_fault;
            shed_prev_q     <= shed_active;
            if (ov_fault && !ov_fault_prev_q && ov_cnt_q != 16'hFFFF) begin
                ov_cnt_q <= ov_cnt_q + 1'b1;
            end
            if (shed_active && !shed_prev_q && shed_cnt_q != 16'hFFFF) begin
                shed_cnt_q <= shed_cnt_q + 1'b1;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // read port: data in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                ovg_pkg::REG_CTRL:    reg_rdata <= {24'h0, ctrl_q};
                ovg_pkg::REG_VNOM:    reg_rdata <= {16'h0, vnom_q};
                ovg_pkg::REG_OV_LVL:
                    reg_rdata <= {16'h0, trip_level_q, warn_level_q};
                ovg_pkg::REG_OV_DLY:  reg_rdata <= {16'h0, ov_dly_q};
                ovg_pkg::REG_DIP_LVL:
                    reg_rdata <= {16'h0, rst_pct_q, dip_pct_q};
                ovg_pkg::REG_DIP_DLY: reg_rdata <= {rstr_dly_q, shed_dly_q};
                ovg_pkg::REG_STATUS:
                    reg_rdata <= {26'h0, shed_q, alarm_led, shed_active,
                                  ov_fault, ov_warn};
                ovg_pkg::REG_COUNT:   reg_rdata <= {shed_cnt_q, ov_cnt_q};
                default:              reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end
endmodule // ovg_guard

// [core/ovg_pkg.sv]
package ovg_pkg;
    // register offsets (word index == byte address, plain port)
    localparam logic [3:0] REG_CTRL      = 4'h0;
    localparam logic [3:0] REG_VNOM      = 4'h1;
    localparam logic [3:0] REG_OV_LVL    = 4'h2;
    localparam logic [3:0] REG_OV_DLY    = 4'h3;
    localparam logic [3:0] REG_DIP_LVL   = 4'h4;
    localparam logic [3:0] REG_DIP_DLY   = 4'h5;
    localparam logic [3:0] REG_STATUS    = 4'h6;
    localparam logic [3:0] REG_COUNT     = 4'h7;
    // control field positions
    localparam int CTRL_WARN_EN  = 0;
    localparam int CTRL_TRIP_EN  = 1;
    localparam int CTRL_MODE_LO  = 2;
    localparam int CTRL_TWO_WIRE = 4;
    localparam int CTRL_OPMODE_LO = 5;
    // reset values
    localparam logic [15:0] VNOM_RST     = 16'h0190;
    localparam logic [7:0]  WARN_PCT_RST = 8'h6E;   // 110 %
    localparam logic [7:0]  TRIP_PCT_RST = 8'h6E;   // 110 %
    localparam logic [15:0] OV_DLY_RST   = 16'h001E; // 3 s in 0.1 s
    localparam logic [7:0]  DIP_PCT_RST  = 8'h46;   // 70 %
    localparam logic [7:0]  RST_PCT_RST  = 8'h5A;   // 90 %
    localparam logic [15:0] SHED_DLY_RST = 16'h000A; // 10 s
    localparam logic [15:0] RSTR_DLY_RST = 16'h0002; // 2 s
    localparam logic [3:0]  HYST_PCT     = 4'h5;
    // dip modes
    localparam logic [1:0] MODE_NONE    = 2'h0;
    localparam logic [1:0] MODE_SHED    = 2'h1;
    localparam logic [1:0] MODE_RESTART = 2'h2;
    // operating modes
    localparam logic [1:0] OPM_OVERLOAD    = 2'h0;
    localparam logic [1:0] OPM_INDEPENDENT = 2'h1;
    // timing
    localparam int CLK_HZ      = 100_000_000;
    localparam int TICK_MS     = 100;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam logic [3:0] TICKS_PER_S = 4'hA;
    localparam int BLINK_MS     = 100;   // half period of 5 flashes/s
    localparam logic [7:0] BLINK_TICKS = 8'h01;
endpackage

// [tb/ovg_guard_monitor.sv]
`timescale 1ns/1ps
module ovg_guard_mon (
    input wire logic        sys_clk,     // clock
    input wire logic        reset,       // sync reset
    input wire logic        module_ok,   // module attached
    input wire logic        motor_ready, // ready state
    input wire logic        motor_run,   // run state
    input wire logic        out1_req,    // output 1 request
    input wire logic        out2_req,    // output 2 request
    input wire logic        reg_rd,      // read strobe
    input wire logic [31:0] reg_rdata,   // read data
    input wire logic        ov_warn,     // warning
    input wire logic        ov_fault,    // fault
    input wire logic        shed_active, // shed status
    input wire logic        motor_stop,  // stop command
    input wire logic        run_cmd,     // restart pulse
    input wire logic        logic_out1,  // gated output 1
    input wire logic        logic_out2,  // gated output 2
    input wire logic        alarm_led    // alarm indicator
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////
    // two samples so a registered gate has settled
    sequence s_off;
        !module_ok ##1 !module_ok;
    endsequence
    sequence s_shed_fall;
        $fell(shed_active);
    endsequence
    property p_unsup;
        s_off |-> !ov_warn && !ov_fault;
    endproperty
    property p_warn_cause;
        $rose(ov_warn) |-> $past(module_ok && (motor_ready || motor_run));
    endproperty
    property p_stop;
        $rose(shed_active) |-> ##[0:1] motor_stop;
    endproperty
    property p_run_fall;
        run_cmd |-> s_shed_fall;
    endproperty
    property p_run_pulse;
        run_cmd |=> !run_cmd;
    endproperty
    property p_rdata;
        !$past(reg_rd) |-> reg_rdata == 32'h0000_0000;
    endproperty
    property p_alarm;
        !shed_active && !$past(shed_active) |-> !alarm_led;
    endproperty
    property p_out1;
        logic_out1 |-> $past(out1_req);
    endproperty
    property p_out2;
        logic_out2 |-> $past(out2_req);
    endproperty
    ////////////////////////////////////////////////////////////////////////
    a_unsup: assert property (p_unsup)
        else $error("overvoltage flag while unsupervised");
    a_warn_cause: assert property (p_warn_cause)
        else $error("warning rose outside ready or run");
    a_stop: assert property (p_stop)
        else $error("shed without stop command");
    a_run_fall: assert property (p_run_fall)
        else $error("run command away from shed clear");
    a_run_pulse: assert property (p_run_pulse)
        else $error("run command longer than one cycle");
    a_rdata: assert property (p_rdata)
        else $error("read data outside its cycle");
    a_alarm: assert property (p_alarm)
        else $error("alarm lit without shedding");
    a_out1: assert property (p_out1)
        else $error("output 1 without request");
    a_out2: assert property (p_out2)
        else $error("output 2 without request");
endmodule // ovg_guard_mon

bind ovg_guard ovg_guard_mon i_mon (
    .sys_clk(sys_clk), .reset(reset), .module_ok(module_ok),
    .motor_ready(motor_ready), .motor_run(motor_run),
    .out1_req(out1_req), .out2_req(out2_req), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ov_warn(ov_warn), .ov_fault(ov_fault),
    .shed_active(shed_active), .motor_stop(motor_stop),
    .run_cmd(run_cmd), .logic_out1(logic_out1),
    .logic_out2(logic_out2), .alarm_led(alarm_led)
);

// [tb/ovg_guard_test.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED at %0t: got %0h exp %0h", $time, g, e); end end
module ovg_guard_test;
    logic        sys_clk, reset, module_ok, out1_req, out2_req, start;
    logic        reg_wr, reg_rd, motor_ready, motor_run;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [15:0] avg_set, peak_set, phase_v1, phase_v2, phase_v3;
    logic        ov_warn, ov_fault, shed_active, motor_stop, run_cmd;
    logic        logic_out1, logic_out2, alarm_led;
    int          err_count, n_compared;
    logic [31:0] rst_tab [0:8] = '{32'h0, 32'h190, 32'h6E6E, 32'h1E,
        32'h5A46, 32'h0002_000A, 32'h0, 32'h0, 32'h0};
    ////////////////////////////////////////////////////////////////////////
    ovg_guard i_dut (.sys_clk(sys_clk), .reset(reset),
        .phase_v1(phase_v1), .phase_v2(phase_v2), .phase_v3(phase_v3),
        .module_ok(module_ok), .motor_ready(motor_ready),
        .motor_run(motor_run), .out1_req(out1_req), .out2_req(out2_req),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ov_warn(ov_warn),
        .ov_fault(ov_fault), .shed_active(shed_active),
        .motor_stop(motor_stop), .run_cmd(run_cmd),
        .logic_out1(logic_out1), .logic_out2(logic_out2),
        .alarm_led(alarm_led));
    ovg_supply i_sup (.sys_clk(sys_clk), .reset(reset), .avg_set(avg_set),
        .peak_set(peak_set), .start(start), .motor_stop(motor_stop),
        .run_cmd(run_cmd), .phase_v1(phase_v1), .phase_v2(phase_v2),
        .phase_v3(phase_v3), .motor_ready(motor_ready),
        .motor_run(motor_run));
    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    // fixed six-cycle wait covers the up to five cycle latency from supply setting to outputs
    task automatic volt(input logic [15:0] a, input logic [15:0] p);
        @(posedge sys_clk);
        avg_set  <= a;
        peak_set <= p;
        repeat (6) @(posedge sys_clk);
        #1;
    endtask
    task automatic complete_run;
        $display("mismatches %0d comparisons %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = !sys_clk;
    end
    initial begin
        #1_000_000;
        err_count++;
        complete_run();
    end
    initial begin
        reset = 1'b1;
        {module_ok, start, reg_wr, reg_rd} = 4'h0;
        {out1_req, out2_req} = 2'h3;
        {reg_addr, reg_wdata} = 36'h0;
        {avg_set, peak_set} = {16'h0190, 16'h0190};
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            rd(i[3:0], d);
            `CHK(d, rst_tab[i]);
        end
        module_ok <= 1'b1;
        start <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
        // warn level 440, clears at 418 or below
        wr(ovg_pkg::REG_CTRL, 32'h1);
        volt(16'h0190, 16'h01B9);
        `CHK(ov_warn, 1'b1);
        volt(16'h0190, 16'h01A3);
        `CHK(ov_warn, 1'b1);
        volt(16'h0190, 16'h01A1);
        `CHK(ov_warn, 1'b0);
        module_ok <= 1'b0;
        volt(16'h0190, 16'h01B9);
        `CHK(ov_warn, 1'b0);
        module_ok <= 1'b1;
        volt(16'h0190, 16'h01B9);
        `CHK(ov_warn, 1'b1);
        wr(ovg_pkg::REG_CTRL, 32'h2);
        wr(ovg_pkg::REG_OV_DLY, 32'h0);
        volt(16'h0190, 16'h01B9);
        `CHK(ov_warn, 1'b0);
        `CHK(ov_fault, 1'b1);
        volt(16'h0190, 16'h01A1);
        `CHK(ov_fault, 1'b0);
        rd(ovg_pkg::REG_COUNT, d);
        `CHK(d[15:0], 16'h0001);
        // dip level 280, restart level 360, both delays immediate
        wr(ovg_pkg::REG_DIP_DLY, 32'h0);
        for (int m = 0; m < 3; m += 2) begin
            wr(ovg_pkg::REG_CTRL, 32'(m) << 2);
            volt(16'h00C8, 16'h00C8);
            `CHK(shed_active, 1'b0);
        end
        volt(16'h00D2, 16'h01AE);
        wr(ovg_pkg::REG_CTRL, 32'h54); // shed, two-wire, all gated
        volt(16'h00D2, 16'h01AE);
        `CHK(shed_active, 1'b0);
        volt(16'h00C8, 16'h01AE);
        `CHK(shed_active, 1'b1);
        `CHK(motor_stop, 1'b1);
        `CHK(motor_run, 1'b0);
        rd(ovg_pkg::REG_STATUS, d);
        `CHK(d & 32'h37, 32'h34);
        for (int m = 0; m < 3; m++) begin
            wr(ovg_pkg::REG_CTRL, 32'h14 | (32'(m) << 5));
            repeat (3) @(posedge sys_clk);
            #1;
            `CHK(logic_out1, (m == 0));
            `CHK(logic_out2, (m != 2));
        end
        out1_req <= 1'b0;
        wr(ovg_pkg::REG_CTRL, 32'h14);
        repeat (3) @(posedge sys_clk);
        #1;
        `CHK(logic_out1, 1'b0);
        volt(16'h0169, 16'h0169);
        `CHK(shed_active, 1'b0);
        `CHK(motor_run, 1'b1);
        `CHK(alarm_led, 1'b0);
        wr(ovg_pkg::REG_CTRL, 32'h44); // three-wire
        volt(16'h00C8, 16'h00C8);
        `CHK(motor_run, 1'b0);
        volt(16'h0169, 16'h0169);
        `CHK(shed_active, 1'b0);
        `CHK(motor_run, 1'b0);
        rd(ovg_pkg::REG_COUNT, d);
        `CHK(d[31:16], 16'h0002);
        complete_run();
    end
endmodule // ovg_guard_test

// [tb/ovg_supply.sv]
`timescale 1ns/1ps
module ovg_supply (
    input  wire logic        sys_clk,    // clock
    input  wire logic        reset,      // sync reset
    input  wire logic [15:0] avg_set,    // level of phases 1 and 3
    input  wire logic [15:0] peak_set,   // level of phase 2
    input  wire logic        start,      // operator start pulse
    input  wire logic        motor_stop, // stop from guard
    input  wire logic        run_cmd,    // restart from guard
    output logic      [15:0] phase_v1,   // L1-L2 voltage
    output logic      [15:0] phase_v2,   // L2-L3 voltage
    output logic      [15:0] phase_v3,   // L3-L1 voltage
    output logic             motor_ready, // ready state
    output logic             motor_run    // run state
);
    logic run_q;
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk) begin
        phase_v1 <= avg_set;
        phase_v2 <= peak_set;
        phase_v3 <= avg_set;
    end
    // stop wins: a contactor cannot close while shed holds it open
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            run_q <= 1'b0;
        end else if (motor_stop) begin
            run_q <= 1'b0;
        end else if (run_cmd || start) begin
            run_q <= 1'b1;
        end
    end
    assign motor_run   = run_q;
    assign motor_ready = !run_q;
endmodule // ovg_supply
